// ### logic/cfb_bank.sv
// Function
// - sensor register readable, written by own command
// - bit1 enables falling edge filter
// - bit0 picks hysteresis tap point
// - latch register readable, written by own command
// - bits7-5 select power latch timeout
// - diag bit gates both low drivers
// - bits3-2 select upstream clock ratio
`include "cfb_defs.svh"

module cfb_bank #(
    parameter int MS_CYCLES = 125000,  // clocks per millisecond
    parameter int FILT_CYC  = 8        // low samples before a fall passes
) (
    input  wire logic        clk_sys,                // system clock
    input  wire logic        nrst,                   // async reset, low
    input  wire logic        wb_cyc_i,               // bus cycle
    input  wire logic        wb_stb_i,               // strobe
    input  wire logic        wb_we_i,                // write enable
    input  wire logic [7:0]  wb_adr_i,               // byte address
    input  wire logic [3:0]  wb_sel_i,               // byte selects
    input  wire logic [31:0] wb_dat_i,               // write data
    output logic [31:0]      wb_dat_o,               // read data
    output logic             wb_ack_o,               // acknowledge
    input  wire logic        crank_sensor_input,     // raw crank pin
    input  wire logic        link_clock_in,          // link clock pin
    input  wire logic        power_latch_active,     // power latch mode pin
    output logic             crank_filtered,         // conditioned crank signal
    output logic             hysteresis_feedback,    // hysteresis feedback tap
    output logic             driver_a_diag_en,       // driver a diag and bias
    output logic             driver_b_diag_en,       // driver b diag and bias
    output logic             upstream_clk_out,       // divided upstream clock
    output logic             kline_slew_limit_on,    // k-line slew limit
    output logic             power_latch_expired     // timeout reached
);

    localparam int PW = $clog2(MS_CYCLES + 1);
    localparam int FW = $clog2(FILT_CYC + 1);

    if (MS_CYCLES < 1) begin : g_chk_ms
        $error("MS_CYCLES must be at least 1");
    end
    if (FILT_CYC < 1) begin : g_chk_filt
        $error("FILT_CYC must be at least 1");
    end

    cfb_pkg::cfb_sensor_cfg_t sensor_cfg;
    cfb_pkg::cfb_latch_cfg_t  latch_cfg;
    cfb_pkg::cfb_tmr_state_t  tmr_state;
    logic [2:0]               sync1;
    logic [2:0]               sync2;
    logic                     link_prev;
    logic                     link_edge;
    logic                     crank_s;
    logic                     active_s;
    logic [FW-1:0]            low_cnt;
    logic [PW-1:0]            pre_cnt;
    logic [22:0]              ms_cnt;
    logic [22:0]              ms_limit;
    logic                     ms_tick;
    logic                     wr_ok;
    logic [31:0]              next_dat;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1     <= 3'h0;
            sync2     <= 3'h0;
            link_prev <= 1'b0;
        end else begin
            sync1     <= {power_latch_active, link_clock_in, crank_sensor_input};
            sync2     <= sync1;
            link_prev <= sync2[1];
        end
    end

    assign crank_s   = sync2[0];
    assign active_s  = sync2[2];
    assign link_edge = sync2[1] & ~link_prev;

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    // lock blocks every write
    assign wr_ok = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0] & ~latch_cfg.lock;

    always_comb begin
        next_dat = 32'h0000_0000;
        unique case (wb_adr_i)
            `CFB_OFS_SENSOR: next_dat = {24'h00_0000, sensor_cfg};
            `CFB_OFS_LATCH:  next_dat = {24'h00_0000, latch_cfg};
            `CFB_OFS_STATUS: next_dat = {27'h000_0000, tmr_state, hysteresis_feedback, crank_filtered};
            default:         next_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= next_dat;
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sensor_cfg <= `CFB_RST_SENSOR;
        end else if (wr_ok && wb_adr_i == `CFB_OFS_SENSOR) begin
            sensor_cfg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            latch_cfg <= `CFB_RST_LATCH;
        end else if (wr_ok && wb_adr_i == `CFB_OFS_LATCH) begin
            latch_cfg      <= wb_dat_i[7:0];
            latch_cfg.lock <= 1'b0;
        end else if (wr_ok && wb_adr_i == `CFB_OFS_LOCK && wb_dat_i[7:0] == `CFB_LOCK_KEY) begin
            latch_cfg.lock <= 1'b1;
        end
    end

    // ----------------------------------------
    // crank input conditioning
    // ----------------------------------------
    // only bits 1 and 0 steer logic
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            crank_filtered <= 1'b0;
            low_cnt        <= '0;
        end else if (crank_s) begin
            crank_filtered <= 1'b1;
            low_cnt        <= '0;
        end else if (!sensor_cfg.falling_edge_filter_on) begin
            crank_filtered <= 1'b0;
            low_cnt        <= '0;
        end else if (low_cnt == FW'(FILT_CYC - 1)) begin
            crank_filtered <= 1'b0;
        end else begin
            low_cnt <= low_cnt + FW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hysteresis_feedback <= 1'b0;
        end else begin
            hysteresis_feedback <= sensor_cfg.hysteresis_tap_select ? crank_filtered : crank_s;
        end
    end

    // ----------------------------------------
    // driver and link outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            driver_a_diag_en    <= 1'b0;
            driver_b_diag_en    <= 1'b0;
            kline_slew_limit_on <= 1'b0;
        end else begin
            driver_a_diag_en    <= latch_cfg.low_current_offstate_diag;
            driver_b_diag_en    <= latch_cfg.low_current_offstate_diag;
            kline_slew_limit_on <= latch_cfg.kline_slew_limit;
        end
    end

    cfb_upstream_div u_div (
        .clk_sys      (clk_sys),
        .nrst         (nrst),
        .link_edge    (link_edge),
        .div_sel      (latch_cfg.upstream_div_sel),
        .upstream_clk (upstream_clk_out)
    );

    // ----------------------------------------
    // power latch timeout
    // ----------------------------------------
    // timeout per select code
    always_comb begin
        unique case (latch_cfg.power_latch_timeout_sel)
            3'h1:    ms_limit = `CFB_TO_SEL1_MS;
            3'h2:    ms_limit = `CFB_TO_SEL2_MS;
            3'h3:    ms_limit = `CFB_TO_SEL3_MS;
            3'h4:    ms_limit = `CFB_TO_SEL4_MS;
            3'h5:    ms_limit = `CFB_TO_SEL5_MS;
            3'h6:    ms_limit = `CFB_TO_SEL6_MS;
            3'h7:    ms_limit = `CFB_TO_SEL7_MS;
            default: ms_limit = 23'h00_0000;
        endcase
    end

    assign ms_tick = (pre_cnt == PW'(MS_CYCLES - 1));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_cnt <= '0;
        end else if (tmr_state != cfb_pkg::CFB_TMR_RUN || ms_tick) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + PW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tmr_state <= cfb_pkg::CFB_TMR_IDLE;
            ms_cnt    <= 23'h00_0000;
        end else begin
            unique case (tmr_state)
                cfb_pkg::CFB_TMR_IDLE: begin
                    ms_cnt <= 23'h00_0000;
                    if (active_s && latch_cfg.power_latch_timeout_sel != 3'h0) begin
                        tmr_state <= cfb_pkg::CFB_TMR_RUN;
                    end
                end
                cfb_pkg::CFB_TMR_RUN: begin
                    if (!active_s || latch_cfg.power_latch_timeout_sel == 3'h0) begin
                        tmr_state <= cfb_pkg::CFB_TMR_IDLE;
                    end else if (ms_tick && ms_cnt >= ms_limit - 23'h00_0001) begin
                        tmr_state <= cfb_pkg::CFB_TMR_EXPIRED;
                    end else if (ms_tick) begin
                        ms_cnt <= ms_cnt + 23'h00_0001;
                    end
                end
                cfb_pkg::CFB_TMR_EXPIRED: begin
                    if (!active_s) begin
                        tmr_state <= cfb_pkg::CFB_TMR_IDLE;
                    end
                end
                default: tmr_state <= cfb_pkg::CFB_TMR_IDLE;
            endcase
        end
    end

    assign power_latch_expired = (tmr_state == cfb_pkg::CFB_TMR_EXPIRED);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    wb_ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given next cycle");
    sensor_write_a: assert property (
        !(wb_ack_o && wb_we_i && wb_adr_i == `CFB_OFS_SENSOR) |=> $stable(sensor_cfg))
        else $error("sensor register changed without command");
    lock_sticky_a: assert property (latch_cfg.lock |=> latch_cfg.lock)
        else $error("lock cleared without reset");
    locked_freeze_a: assert property (latch_cfg.lock |=> $stable(sensor_cfg) && $stable(latch_cfg))
        else $error("locked register changed");
    filter_bypass_a: assert property (
        !sensor_cfg.falling_edge_filter_on && $past(!sensor_cfg.falling_edge_filter_on)
        |-> crank_filtered == $past(crank_s))
        else $error("filter not bypassed");
    filter_fall_a: assert property (
        $fell(crank_filtered) && $past(sensor_cfg.falling_edge_filter_on)
        |-> $past(low_cnt) == FW'(FILT_CYC - 1))
        else $error("filtered fall too early");
    hyst_tap_a: assert property (
        ##1 hysteresis_feedback == ($past(sensor_cfg.hysteresis_tap_select) ? $past(crank_filtered) : $past(crank_s)))
        else $error("wrong hysteresis tap");
    diag_pair_a: assert property (
        ##1 driver_a_diag_en == driver_b_diag_en && driver_a_diag_en == $past(latch_cfg.low_current_offstate_diag))
        else $error("driver diag enables disagree");
    timeout_exact_a: assert property (
        $rose(power_latch_expired) |-> $past(ms_cnt) == $past(ms_limit) - 23'h00_0001 && $past(ms_tick))
        else $error("timeout at wrong count");
    timeout_off_a: assert property (latch_cfg.power_latch_timeout_sel == 3'h0 |=> !$rose(power_latch_expired))
        else $error("disabled timeout expired");

    lock_set_c: cover property ($rose(latch_cfg.lock));
    expired_c: cover property ($rose(power_latch_expired));
    filt_fall_c: cover property ($fell(crank_filtered) && sensor_cfg.falling_edge_filter_on);

endmodule

// ### logic/cfb_defs.svh
`ifndef CFB_DEFS_SVH
`define CFB_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CFB_OFS_SENSOR   8'h08
`define CFB_OFS_LATCH    8'h0c
`define CFB_OFS_LOCK     8'h10
`define CFB_OFS_STATUS   8'h14

// ----------------------------------------
// reset values and lock key
// ----------------------------------------
`define CFB_RST_SENSOR   8'h08
`define CFB_RST_LATCH    8'h02
`define CFB_LOCK_KEY     8'h01

// ----------------------------------------
// timeouts in ms per select code
// ----------------------------------------
`define CFB_TO_SEL1_MS   23'h044d90
`define CFB_TO_SEL2_MS   23'h083d60
`define CFB_TO_SEL3_MS   23'h1164a0
`define CFB_TO_SEL4_MS   23'h19a280
`define CFB_TO_SEL5_MS   23'h21df60
`define CFB_TO_SEL6_MS   23'h44aa20
`define CFB_TO_SEL7_MS   23'h0001d6

// ----------------------------------------
// link edges per upstream half period
// ----------------------------------------
`define CFB_HALF_DIV64   7'h20
`define CFB_HALF_DIV16   7'h08
`define CFB_HALF_DIV32   7'h10
`define CFB_HALF_DIV128  7'h40

`endif

// ### logic/cfb_pkg.sv
package cfb_pkg;

    typedef struct packed {
        logic [5:0] spare;
        logic       falling_edge_filter_on;
        logic       hysteresis_tap_select;
    } cfb_sensor_cfg_t;

    typedef struct packed {
        logic [2:0] power_latch_timeout_sel;
        logic       low_current_offstate_diag;
        logic [1:0] upstream_div_sel;
        logic       kline_slew_limit;
        logic       lock;
    } cfb_latch_cfg_t;

    typedef enum logic [2:0] {
        CFB_TMR_IDLE    = 3'b001,
        CFB_TMR_RUN     = 3'b010,
        CFB_TMR_EXPIRED = 3'b100
    } cfb_tmr_state_t;

endpackage

// ### logic/cfb_upstream_div.sv
`include "cfb_defs.svh"

module cfb_upstream_div (
    input  wire logic       clk_sys,      // system clock
    input  wire logic       nrst,         // async reset, low
    input  wire logic       link_edge,    // one pulse per link clock rising edge
    input  wire logic [1:0] div_sel,      // ratio select
    output logic            upstream_clk  // divided clock level
);

    logic [6:0] half;
    logic [6:0] cnt;

    // ----------------------------------------
    // ratio decode
    // ----------------------------------------
    // ratio per select
    always_comb begin
        unique case (div_sel)
            2'b00: half = `CFB_HALF_DIV64;
            2'b01: half = `CFB_HALF_DIV16;
            2'b10: half = `CFB_HALF_DIV32;
            2'b11: half = `CFB_HALF_DIV128;
        endcase
    end

    // ----------------------------------------
    // edge counter and toggle
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt          <= 7'h00;
            upstream_clk <= 1'b0;
        end else if (link_edge) begin
            // ratio change mid-period keeps the count; a count at or past the new half ends the period on the next edge
            if (cnt >= half - 7'h01) begin
                cnt          <= 7'h00;
                upstream_clk <= ~upstream_clk;
            end else begin
                cnt <= cnt + 7'h01;
            end
        end
    end

endmodule

// ### tb/cfb_host_model.sv
module cfb_host_model (
    input  wire logic        clk_sys,  // system clock
    output logic             wb_cyc_i, // bus cycle
    output logic             wb_stb_i, // strobe
    output logic             wb_we_i,  // write enable
    output logic [7:0]       wb_adr_i, // byte address
    output logic [3:0]       wb_sel_i, // byte selects
    output logic [31:0]      wb_dat_i, // write data
    input  wire logic [31:0] wb_dat_o, // read data
    input  wire logic        wb_ack_o  // acknowledge
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
    end

    // ----------------------------------------
    // classic single cycle
    // ----------------------------------------
    // command bus cycles
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] dat, output logic [31:0] rdat);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= ~we;
        wb_adr_i <= ~adr;
        wb_sel_i <= ~sel;
        wb_dat_i <= ~dat;
    endtask
endmodule

// ### tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        crank_sensor_input, link_clock_in, power_latch_active;
    logic        crank_filtered, hysteresis_feedback, driver_a_diag_en, driver_b_diag_en;
    logic        upstream_clk_out, kline_slew_limit_on, power_latch_expired;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    int          seed       = 32'h3421;
    int          cyc_cnt    = 0;
    int          hp[4]      = '{32, 8, 16, 64};
    logic [7:0]  esns, elat;
    logic        lk;
    logic [31:0] rv;

    cfb_bank #(.MS_CYCLES(4), .FILT_CYC(3)) dut (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .crank_sensor_input, .link_clock_in,
        .power_latch_active, .crank_filtered, .hysteresis_feedback, .driver_a_diag_en,
        .driver_b_diag_en, .upstream_clk_out, .kline_slew_limit_on, .power_latch_expired);
    cfb_host_model h (.clk_sys, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ----------------------------------------
    // compare and bus helpers
    // ----------------------------------------
    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t pin %b expected %b", $time, got, exp);
        end
    endtask

    task automatic mreset();
        esns = 8'h08;
        elat = 8'h02;
        lk   = 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        h.xfer(1'b1, a, s, d, rv);
        if (s[0] && a == 8'h08 && !lk) esns = d[7:0];
        if (s[0] && a == 8'h0c && !lk) elat = {d[7:1], 1'b0};
        if (s[0] && a == 8'h10 && d[7:0] == 8'h01) lk = 1'b1;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        h.xfer(1'b0, a, 4'hf, $random(seed), rv);
        chkv(rv, e);
    endtask

    task automatic rdregs();
        rdc(8'h08, {24'h0, esns});
        rdc(8'h0c, {24'h0, elat[7:1], lk});
    endtask

    task automatic pulse(input int len, input logic fe, input logic tap);
        int         lo_f;
        int         lo_h;
        logic [7:0] d;
        lo_f = 0;
        lo_h = 0;
        d = $random(seed);
        wr(8'h08, 4'h1, {24'h0, d[7:2], fe, tap});
        for (int i = 0; i < len + 12; i++) begin
            @(posedge clk_sys);
            crank_sensor_input <= (i >= len);
            if (crank_filtered === 1'b0) lo_f++;
            if (hysteresis_feedback === 1'b0) lo_h++;
        end
        chk1(lo_f != 0, !fe || len > 3);
        chk1(lo_h != 0, !tap || !fe || len > 3);
    endtask

    task automatic divt(input int s);
        int   tg;
        logic pv;
        logic dg;
        dg = $random(seed);
        wr(8'h0c, 4'h1, {24'h0, 3'h0, dg, s[1:0], 2'b10});
        tg = 0;
        pv = upstream_clk_out;
        for (int i = 0; i < 2048; i++) begin
            @(posedge clk_sys);
            link_clock_in <= i[1];
            if (upstream_clk_out !== pv) tg++;
            pv = upstream_clk_out;
        end
        chk1(tg >= 512 / hp[s] - 1 && tg <= 512 / hp[s] + 1, 1'b1);
        chk1(driver_a_diag_en, dg);
        chk1(driver_b_diag_en, dg);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] adrs[4];
        adrs = '{8'h08, 8'h0c, 8'h14, 8'h24};
        nrst = 1'b0;
        crank_sensor_input = 1'b1;
        link_clock_in = 1'b0;
        power_latch_active = 1'b0;
        mreset();
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        rdregs();
        chk1(kline_slew_limit_on, 1'b1);
        for (int i = 0; i < 20; i++) begin
            wr(adrs[$random(seed) & 3], $random(seed), $random(seed));
            rdregs();
            chk1(driver_a_diag_en, elat[4]);
            chk1(kline_slew_limit_on, elat[1]);
        end
        rdc(8'h10, 32'h0);
        rdc(8'h30, 32'h0);
        for (int m = 0; m < 8; m++) pulse(m[2] ? 8 : 2, m[1], m[0]);
        for (int s = 0; s < 4; s++) divt(s);
        for (int c = 1; c < 8; c++) begin
            power_latch_active <= 1'b0;
            wr(8'h0c, 4'h1, {24'h0, c[2:0], 5'h02});
            power_latch_active <= 1'b1;
            repeat (20) @(posedge clk_sys);
            rdc(8'h14, 32'h0000000b);
        end
        repeat (1700) @(posedge clk_sys);
        chk1(power_latch_expired, 1'b0);
        repeat (230) @(posedge clk_sys);
        chk1(power_latch_expired, 1'b1);
        rdc(8'h14, 32'h00000013);
        // expired level held past a disable, ends when active drops
        wr(8'h0c, 4'h1, 32'h02);
        repeat (20) @(posedge clk_sys);
        rdc(8'h14, 32'h00000013);
        power_latch_active <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rdc(8'h14, 32'h00000007);
        wr(8'h10, 4'h1, 32'h02);
        wr(8'h0c, 4'h1, 32'hff);
        wr(8'h10, 4'h0, 32'h01);
        rdregs();
        wr(8'h10, 4'h1, 32'h01);
        rdregs();
        wr(8'h08, 4'h1, $random(seed));
        wr(8'h0c, 4'h1, $random(seed));
        rdregs();
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        mreset();
        rdregs();
        end_sim();
    end
endmodule
